// ---- hdl/uif_params.svh ----
`ifndef UIF_PARAMS_SVH
`define UIF_PARAMS_SVH
// ****************************************
// Register offsets
// ****************************************
`define UIF_OFS_EVT 8'h00
`define UIF_OFS_EEN 8'h04
`define UIF_OFS_ERR 8'h08
`define UIF_OFS_RER 8'h0c
`define UIF_OFS_TOK 8'h10
`define UIF_OFS_MOD 8'h14
// ****************************************
// Field positions
// ****************************************
`define UIF_B_STALL 7
`define UIF_B_ATTACH 6
`define UIF_B_RESUME 5
`define UIF_B_IDLE 4
`define UIF_B_TOKEN 3
`define UIF_B_SOF 2
`define UIF_B_SUMMARY 1
`define UIF_B_RSTDET 0
`define UIF_E_STUFF 7
`define UIF_E_DMA 5
`define UIF_E_TURN 4
`define UIF_E_FIELD 3
`define UIF_E_CRC16 2
`define UIF_E_TOKCRC 1
`define UIF_E_PID 0
`define UIF_M_HOST 0
`define UIF_M_LOWSPD 1
// ****************************************
// Reset values and masks
// ****************************************
`define UIF_RST8 8'h00
`define UIF_RST32 32'h00000000
`define UIF_ERR_MASK 8'hbf
`define UIF_HSIZE_WORD 3'h2
// ****************************************
// Timing and token queue depth
// ****************************************
`define UIF_CLK_KHZ 40000
`define UIF_T_RESUME_NS 2500
`define UIF_T_RESET_NS 2500
`define UIF_T_ATTACH_NS 2500
`define UIF_T_IDLE_MS 3
`define UIF_CYC_MIN_NS(ns) (((ns) * `UIF_CLK_KHZ + 999999) / 1000000)
`define UIF_CYC_IDLE (`UIF_T_IDLE_MS * `UIF_CLK_KHZ)
`define UIF_TOK_DEPTH 4
`endif

// ---- hdl/uif_pkg.sv ----
package uif_pkg;
   typedef struct packed {
      logic        hsel;
      logic [7:0]  haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hready;
      logic [31:0] hwdata;
   } uif_ahb_req_t;
   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } uif_ahb_rsp_t;
   typedef struct packed {
      logic dp;
      logic dm;
   } uif_line_t;
   typedef enum logic [1:0] {
      UIF_SE0,
      UIF_J,
      UIF_K,
      UIF_SE1
   } uif_lstate_t;
endpackage : uif_pkg

// ---- hdl/uif_top.sv ----
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "uif_params.svh"

// ****************************************
// Held-condition detector
// ****************************************
module uif_hold_det #(
   parameter int CYC = 100
) (
   input  wire logic ref_clk,
   input  wire logic reset_n,
   input  wire logic cond,
   output logic      fire
);
   logic [31:0] cnt_reg;
   // Fires once per unbroken period; rearms only when cond drops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= `UIF_RST32;
      end else if (!cond) begin
         cnt_reg <= `UIF_RST32;
      end else if (cnt_reg < 32'(CYC)) begin
         cnt_reg <= cnt_reg + 32'h1;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         fire <= 1'b0;
      end else begin
         fire <= cond && (cnt_reg == 32'(CYC - 1));
      end
   end
endmodule : uif_hold_det

// ****************************************
// Top
// ****************************************
module uif_top
   import uif_pkg::*;
#(
   parameter int IDLE_CYC = `UIF_CYC_IDLE
) (
   input  wire logic         ref_clk,
   input  wire logic         reset_n,
   input  wire uif_ahb_req_t ahbReq,
   output uif_ahb_rsp_t      ahbRsp,
   input  wire uif_line_t    usbLine,
   input  wire logic         busActivity,
   input  wire logic         stallSent,
   input  wire logic         tokenDone,
   input  wire logic [7:0]   tokenInfo,
   input  wire logic         sofToken,
   input  wire logic         sofThreshold,
   input  wire logic         stuffError,
   input  wire logic         turnTimeout,
   input  wire logic         fieldSizeError,
   input  wire logic         crc16Fail,
   input  wire logic         crc16Pass,
   input  wire logic         tokenCrcError,
   input  wire logic         frameEndError,
   input  wire logic         pidFail,
   input  wire logic         rxByteStrobe,
   input  wire logic [9:0]   rxByteCount,
   input  wire logic [9:0]   descByteCount,
   output logic              rxByteStore,
   output logic              usbIrq
);
   localparam int RESUME_CYC = `UIF_CYC_MIN_NS(`UIF_T_RESUME_NS);
   localparam int RESET_CYC  = `UIF_CYC_MIN_NS(`UIF_T_RESET_NS);
   localparam int ATTACH_CYC = `UIF_CYC_MIN_NS(`UIF_T_ATTACH_NS);

   logic        dphValid_reg;
   logic        dphWrite_reg;
   logic [7:0]  dphAddr_reg;
   logic [2:0]  dphSize_reg;
   logic        rdDone_reg;
   logic [31:0] rdData_reg;
   logic        readyOut;
   logic        wrWord;
   logic        wrEvt;
   logic        wrEen;
   logic        wrErr;
   logic        wrRer;
   logic        wrMod;
   logic [7:0]  evtFlags_reg;
   logic [7:0]  evtEn_reg;
   logic [7:0]  errFlags_reg;
   logic [7:0]  errEn_reg;
   logic [1:0]  mode_reg;
   logic        hostMode;
   logic        lowSpeed;
   uif_lstate_t lineState;
   logic        resumeFire;
   logic        se0Fire;
   logic        attachFire;
   logic        idleFire;
   logic [7:0]  evtSet;
   logic [7:0]  evtClr;
   logic [7:0]  errSet;
   logic [7:0]  errClr;
   logic [7:0]  evtView;
   logic [7:0]  evtEnView;
   logic        errSummary;
   logic        tokNotEmpty;
   logic        tokPop;
   logic        tokPush;
   logic [7:0]  tokMem [`UIF_TOK_DEPTH];
   logic [1:0]  tokRd_reg;
   logic [1:0]  tokWr_reg;
   logic [2:0]  tokCnt_reg;
   logic        dmaOver;
   logic [31:0] rdValue;

   assign hostMode = mode_reg[`UIF_M_HOST];
   assign lowSpeed = mode_reg[`UIF_M_LOWSPD];

   // ****************************************
   // AHB-Lite slave
   // ****************************************
   // Reads take one wait state so that hrdata comes from a flop and
   // reflects any write completed in the cycle before.
   assign readyOut = !(dphValid_reg && !dphWrite_reg && !rdDone_reg);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         dphValid_reg <= 1'b0;
         dphWrite_reg <= 1'b0;
         dphAddr_reg  <= `UIF_RST8;
         dphSize_reg  <= 3'h0;
      end else if (ahbReq.hready) begin
         dphValid_reg <= ahbReq.hsel && ahbReq.htrans[1];
         dphWrite_reg <= ahbReq.hwrite;
         dphAddr_reg  <= ahbReq.haddr;
         dphSize_reg  <= ahbReq.hsize;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdDone_reg <= 1'b0;
      end else begin
         rdDone_reg <= !readyOut;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_reg <= `UIF_RST32;
      end else if (!readyOut) begin
         rdData_reg <= rdValue;
      end
   end

   // Narrow writes are ignored: a byte write must not clear flags
   assign wrWord = dphValid_reg && dphWrite_reg && readyOut
                   && (dphSize_reg == `UIF_HSIZE_WORD);
   assign wrEvt = wrWord && (dphAddr_reg == `UIF_OFS_EVT);
   assign wrEen = wrWord && (dphAddr_reg == `UIF_OFS_EEN);
   assign wrErr = wrWord && (dphAddr_reg == `UIF_OFS_ERR);
   assign wrRer = wrWord && (dphAddr_reg == `UIF_OFS_RER);
   assign wrMod = wrWord && (dphAddr_reg == `UIF_OFS_MOD);

   always_comb begin
      rdValue = `UIF_RST32;
      case (dphAddr_reg)
         `UIF_OFS_EVT: rdValue = {24'h0, evtView};
         `UIF_OFS_EEN: rdValue = {24'h0, evtEnView};
         `UIF_OFS_ERR: rdValue = {24'h0, errFlags_reg};
         `UIF_OFS_RER: rdValue = {24'h0, errEn_reg};
         `UIF_OFS_TOK: rdValue = {24'h0, tokMem[tokRd_reg]};
         `UIF_OFS_MOD: rdValue = {30'h0, mode_reg};
         default:      rdValue = `UIF_RST32;
      endcase
   end

   assign ahbRsp.hrdata    = rdData_reg;
   assign ahbRsp.hreadyout = readyOut;
   assign ahbRsp.hresp     = 1'b0;

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         evtEn_reg <= `UIF_RST8;
      end else if (wrEen) begin
         evtEn_reg <= ahbReq.hwdata[7:0];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         errEn_reg <= `UIF_RST8;
      end else if (wrRer) begin
         errEn_reg <= ahbReq.hwdata[7:0] & `UIF_ERR_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= 2'h0;
      end else if (wrMod) begin
         mode_reg <= ahbReq.hwdata[1:0];
      end
   end

   // ****************************************
   // Line state decode
   // ****************************************
   // J and K swap with speed; SE1 is treated as neither
   always_comb begin
      case ({usbLine.dp, usbLine.dm})
         2'b00:   lineState = UIF_SE0;
         2'b10:   lineState = lowSpeed ? UIF_K : UIF_J;
         2'b01:   lineState = lowSpeed ? UIF_J : UIF_K;
         default: lineState = UIF_SE1;
      endcase
   end

   uif_hold_det #(.CYC(RESUME_CYC)) uResume (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .cond    (lineState == UIF_K),
      .fire    (resumeFire)
   );

   // Device: bus reset; host: peripheral removal shows as held SE0
   uif_hold_det #(.CYC(RESET_CYC)) uSe0 (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .cond    (lineState == UIF_SE0),
      .fire    (se0Fire)
   );

   uif_hold_det #(.CYC(ATTACH_CYC)) uAttach (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .cond    (hostMode && (lineState != UIF_SE0) && !busActivity),
      .fire    (attachFire)
   );

   uif_hold_det #(.CYC(IDLE_CYC)) uIdle (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .cond    (lineState == UIF_J),
      .fire    (idleFire)
   );

   // ****************************************
   // Event flags
   // ****************************************
   always_comb begin
      evtSet = `UIF_RST8;
      evtSet[`UIF_B_STALL]  = stallSent;
      evtSet[`UIF_B_ATTACH] = attachFire && hostMode;
      evtSet[`UIF_B_RESUME] = resumeFire;
      evtSet[`UIF_B_IDLE]   = idleFire;
      evtSet[`UIF_B_SOF]    = hostMode ? sofThreshold : sofToken;
      evtSet[`UIF_B_RSTDET] = se0Fire;
   end

   assign evtClr = wrEvt ? ahbReq.hwdata[7:0] : `UIF_RST8;

   // Set wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         evtFlags_reg <= `UIF_RST8;
      end else begin
         evtFlags_reg <= (evtFlags_reg & ~evtClr) | evtSet;
      end
   end

   assign errSummary = |(errFlags_reg & errEn_reg);

   always_comb begin
      evtView = evtFlags_reg;
      evtView[`UIF_B_ATTACH]  = evtFlags_reg[`UIF_B_ATTACH] && hostMode;
      evtView[`UIF_B_TOKEN]   = tokNotEmpty;
      evtView[`UIF_B_SUMMARY] = errSummary;
   end

   always_comb begin
      evtEnView = evtEn_reg;
      evtEnView[`UIF_B_ATTACH] = evtEn_reg[`UIF_B_ATTACH] && hostMode;
   end

   // ****************************************
   // Token status queue
   // ****************************************
   // A token finishing while the queue is full is dropped; the engine
   // is expected to hold off until software has drained it.
   assign tokNotEmpty = (tokCnt_reg != 3'h0);
   assign tokPop  = evtClr[`UIF_B_TOKEN] && tokNotEmpty;
   assign tokPush = tokenDone && (tokCnt_reg != 3'(`UIF_TOK_DEPTH));

   always_ff @(posedge ref_clk) begin
      if (tokPush) begin
         tokMem[tokWr_reg] <= tokenInfo;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tokWr_reg <= 2'h0;
         tokRd_reg <= 2'h0;
      end else begin
         if (tokPush) begin
            tokWr_reg <= tokWr_reg + 2'h1;
         end
         if (tokPop) begin
            tokRd_reg <= tokRd_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tokCnt_reg <= 3'h0;
      end else begin
         case ({tokPush, tokPop})
            2'b10:   tokCnt_reg <= tokCnt_reg + 3'h1;
            2'b01:   tokCnt_reg <= tokCnt_reg - 3'h1;
            default: tokCnt_reg <= tokCnt_reg;
         endcase
      end
   end

   // ****************************************
   // Receive overrun and truncation
   // ****************************************
   assign dmaOver = rxByteStrobe && (rxByteCount > descByteCount);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rxByteStore <= 1'b0;
      end else begin
         rxByteStore <= rxByteStrobe && !dmaOver;
      end
   end

   // ****************************************
   // Error flags
   // ****************************************
   always_comb begin
      errSet = `UIF_RST8;
      errSet[`UIF_E_STUFF]  = stuffError;
      errSet[`UIF_E_DMA]    = dmaOver;
      errSet[`UIF_E_TURN]   = turnTimeout;
      errSet[`UIF_E_FIELD]  = fieldSizeError;
      errSet[`UIF_E_CRC16]  = crc16Fail && !crc16Pass;
      errSet[`UIF_E_TOKCRC] = hostMode ? frameEndError : tokenCrcError;
      errSet[`UIF_E_PID]    = pidFail;
   end

   assign errClr = wrErr ? ahbReq.hwdata[7:0] : `UIF_RST8;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         errFlags_reg <= `UIF_RST8;
      end else begin
         errFlags_reg <= (errFlags_reg & ~errClr) | errSet;
      end
   end

   // ****************************************
   // Interrupt request
   // ****************************************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         usbIrq <= 1'b0;
      end else begin
         usbIrq <= |(evtView & evtEnView);
      end
   end
endmodule : uif_top

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
   import uif_pkg::*;
;
   logic         ref_clk;
   logic         reset_n;
   logic         lowSpd;
   logic         crc16Pass;
   logic         rxByteStrobe;
   logic         busActivity;
   logic         rxByteStore;
   logic         usbIrq;
   logic [10:0]  evt;
   logic [7:0]   tokenInfo;
   logic [9:0]   rxByteCount;
   logic [9:0]   descByteCount;
   logic [31:0]  rdv;
   uif_ahb_req_t reqDrv;
   uif_ahb_req_t ahbReq;
   uif_ahb_rsp_t ahbRsp;
   uif_line_t    usbLine;
   int           errTotal;
   int           checks;
   // Offset and expected flag for event inputs 0 to 8
   logic [15:0]  rows [9] = '{16'h0080, 16'h0008, 16'h0004, 16'h0880, 16'h0810,
                              16'h0808, 16'h0804, 16'h0802, 16'h0801};
   always_comb begin
      ahbReq = reqDrv;
      ahbReq.hready = ahbRsp.hreadyout;
   end
   uif_top #(.IDLE_CYC(200)) u_uif_top (.ref_clk, .reset_n, .ahbReq, .ahbRsp, .usbLine,
      .busActivity, .stallSent(evt[0]), .tokenDone(evt[1]), .tokenInfo, .sofToken(evt[2]),
      .sofThreshold(evt[9]), .stuffError(evt[3]), .turnTimeout(evt[4]),
      .fieldSizeError(evt[5]), .crc16Fail(evt[6]), .crc16Pass, .tokenCrcError(evt[7]),
      .frameEndError(evt[10]), .pidFail(evt[8]), .rxByteStrobe, .rxByteCount,
      .descByteCount, .rxByteStore, .usbIrq);
   uif_usb_peer u_uif_usb_peer (.ref_clk, .lowSpd, .usbLine, .busActivity);
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // ****************************************
   // Bus, check and stimulus tasks
   // ****************************************
   task automatic endSim();
      if (errTotal == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : endSim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errTotal++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // hready is sampled mid-cycle, where it is settled
   task automatic waitRdy();
      int n;
      n = 0;
      @(negedge ref_clk);
      while (ahbRsp.hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            errTotal++;
            $display("MISMATCH t=%0t bus hang", $time);
            endSim();
         end
         @(negedge ref_clk);
      end
      rdv = ahbRsp.hrdata;
      @(posedge ref_clk);
   endtask : waitRdy
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      reqDrv.hsel <= 1'b1;
      reqDrv.htrans <= 2'b10;
      reqDrv.haddr <= a;
      reqDrv.hwrite <= w;
      waitRdy();
      reqDrv.hsel <= 1'b0;
      reqDrv.htrans <= 2'b00;
      reqDrv.hwdata <= d;
      waitRdy();
   endtask : xfer
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask : rdChk
   task automatic pulse(input int i);
      evt[i] <= 1'b1;
      @(posedge ref_clk);
      evt <= '0;
      @(posedge ref_clk);
   endtask : pulse
   task automatic strobe(input logic [9:0] c);
      rxByteCount <= c;
      rxByteStrobe <= 1'b1;
      @(posedge ref_clk);
      rxByteStrobe <= 1'b0;
      @(posedge ref_clk);
   endtask : strobe
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      reset_n = 1'b0;
      reqDrv = '0;
      reqDrv.hsize = 3'h2;
      evt = '0;
      tokenInfo = 8'h00;
      crc16Pass = 1'b0;
      lowSpd = 1'b0;
      rxByteStrobe = 1'b0;
      rxByteCount = 10'h000;
      descByteCount = 10'h004;
      errTotal = 0;
      checks = 0;
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      for (int a = 0; a < 20; a += 4)
         rdChk(a[7:0], 32'h0);
      xfer(1'b1, 8'h3c, 32'hff);
      rdChk(8'h3c, 32'h0);
      for (int i = 0; i < 9; i++) begin
         pulse(i);
         rdChk(rows[i][15:8], {24'h0, rows[i][7:0]});
         xfer(1'b1, rows[i][15:8], {24'h0, rows[i][7:0]});
         rdChk(rows[i][15:8], 32'h0);
      end
      reqDrv.hsize <= 3'h0;
      xfer(1'b1, 8'h04, 32'hff);
      reqDrv.hsize <= 3'h2;
      rdChk(8'h04, 32'h0);
      xfer(1'b1, 8'h04, 32'hffffffff);
      rdChk(8'h04, 32'hbf);
      xfer(1'b1, 8'h04, 32'h80);
      pulse(0);
      pulse(2);
      chk(usbIrq, 1'b1);
      xfer(1'b1, 8'h00, 32'h04);
      rdChk(8'h00, 32'h80);
      xfer(1'b1, 8'h00, 32'h80);
      repeat (2) @(posedge ref_clk);
      chk(usbIrq, 1'b0);
      xfer(1'b1, 8'h04, 32'h0);
      xfer(1'b1, 8'h0c, 32'h01);
      pulse(8);
      xfer(1'b1, 8'h00, 32'h02);
      rdChk(8'h00, 32'h02);
      xfer(1'b1, 8'h08, 32'h01);
      rdChk(8'h00, 32'h0);
      tokenInfo <= 8'h11;
      pulse(1);
      tokenInfo <= 8'h22;
      pulse(1);
      rdChk(8'h10, 32'h11);
      xfer(1'b1, 8'h00, 32'h08);
      rdChk(8'h10, 32'h22);
      rdChk(8'h00, 32'h08);
      xfer(1'b1, 8'h00, 32'h08);
      strobe(10'h005);
      strobe(10'h004);
      rdChk(8'h08, 32'h20);
      xfer(1'b1, 8'h08, 32'h20);
      // A passing check in the same cycle must not raise the flag
      crc16Pass <= 1'b1;
      pulse(6);
      crc16Pass <= 1'b0;
      rdChk(8'h08, 32'h0);
      u_uif_usb_peer.hold(UIF_SE0, 120);
      rdChk(8'h00, 32'h01);
      xfer(1'b1, 8'h00, 32'h01);
      u_uif_usb_peer.hold(UIF_SE0, 120);
      rdChk(8'h00, 32'h0);
      u_uif_usb_peer.hold(UIF_K, 50);
      rdChk(8'h00, 32'h0);
      u_uif_usb_peer.hold(UIF_K, 70);
      rdChk(8'h00, 32'h20);
      xfer(1'b1, 8'h00, 32'h20);
      u_uif_usb_peer.hold(UIF_J, 250);
      rdChk(8'h00, 32'h10);
      u_uif_usb_peer.hold(UIF_SE1, 1);
      xfer(1'b1, 8'h00, 32'h10);
      lowSpd <= 1'b1;
      xfer(1'b1, 8'h14, 32'h03);
      xfer(1'b1, 8'h04, 32'hff);
      rdChk(8'h04, 32'hff);
      xfer(1'b1, 8'h04, 32'h0);
      pulse(9);
      pulse(10);
      rdChk(8'h08, 32'h02);
      xfer(1'b1, 8'h08, 32'h02);
      u_uif_usb_peer.hold(UIF_J, 120);
      rdChk(8'h00, 32'h44);
      xfer(1'b1, 8'h00, 32'h44);
      u_uif_usb_peer.hold(UIF_SE0, 120);
      rdChk(8'h00, 32'h01);
      xfer(1'b1, 8'h04, 32'hff);
      repeat (2) @(posedge ref_clk);
      chk(usbIrq, 1'b1);
      // Reset in mid-run must drop flags, enables, mode and the request
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      chk(usbIrq, 1'b0);
      rdChk(8'h00, 32'h0);
      rdChk(8'h04, 32'h0);
      rdChk(8'h14, 32'h0);
      endSim();
   end
endmodule : tb_top
bind uif_top uif_props u_uif_props (.ref_clk, .reset_n, .ahbReq, .ahbRsp, .rxByteStrobe,
   .rxByteCount, .descByteCount, .rxByteStore, .usbIrq);

// ---- tb/uif_props.sv ----
`timescale 1ns/10ps
module uif_props
   import uif_pkg::*;
(
   input wire logic         ref_clk,
   input wire logic         reset_n,
   input wire uif_ahb_req_t ahbReq,
   input wire uif_ahb_rsp_t ahbRsp,
   input wire logic         rxByteStrobe,
   input wire logic [9:0]   rxByteCount,
   input wire logic [9:0]   descByteCount,
   input wire logic         rxByteStore,
   input wire logic         usbIrq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   wire logic taken = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
   logic      wrEen;
   logic      enZero;
   // Mirror of enable writes: all-zero enables must silence the request
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrEen <= 1'b0;
         enZero <= 1'b1;
      end else if (ahbReq.hready) begin
         // Narrow writes leave the enables alone, so the mirror must skip them too
         wrEen <= taken && ahbReq.hwrite && ahbReq.haddr == 8'h04
                  && ahbReq.hsize == 3'h2;
         if (wrEen)
            enZero <= ahbReq.hwdata[7:0] == 8'h00;
      end
   end
   property p_read_wait;
      taken && !ahbReq.hwrite |=> !ahbRsp.hreadyout ##1 ahbRsp.hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
   property p_write_nowait;
      taken && ahbReq.hwrite |=> ahbRsp.hreadyout;
   endproperty
   a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
   property p_rdata_hold;
      ahbRsp.hreadyout |=> $stable(ahbRsp.hrdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_upper_zero;
      ahbRsp.hrdata[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
   property p_resp_okay;
      !ahbRsp.hresp;
   endproperty
   a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
   property p_dma_drop;
      rxByteStrobe && rxByteCount > descByteCount |=> !rxByteStore;
   endproperty
   a_dma_drop: assert property (p_dma_drop) else $error("overrun byte stored");
   property p_store_ok;
      rxByteStrobe && rxByteCount <= descByteCount |=> rxByteStore;
   endproperty
   a_store_ok: assert property (p_store_ok) else $error("fitting byte lost");
   property p_store_idle;
      !rxByteStrobe |=> !rxByteStore;
   endproperty
   a_store_idle: assert property (p_store_idle) else $error("store without byte");
   property p_irq_masked;
      $past(enZero) |-> !usbIrq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("request while masked");
endmodule : uif_props

// ---- tb/uif_usb_peer.sv ----
`timescale 1ns/10ps
module uif_usb_peer
   import uif_pkg::*;
(
   input wire logic  ref_clk,
   input wire logic  lowSpd,
   output uif_line_t usbLine,
   output logic      busActivity
);
   uif_lstate_t st = UIF_SE1;
   initial busActivity = 1'b0;
   // J and K swap polarity with bus speed
   always_comb begin
      case (st)
         UIF_SE0: usbLine = 2'b00;
         UIF_J:   usbLine = {~lowSpd, lowSpd};
         UIF_K:   usbLine = {lowSpd, ~lowSpd};
         default: usbLine = 2'b11;
      endcase
   end
   // A line change counts as activity for one cycle
   task automatic hold(input uif_lstate_t s, input int n);
      busActivity <= s != st;
      st <= s;
      @(posedge ref_clk);
      busActivity <= 1'b0;
      repeat (n) @(posedge ref_clk);
   endtask : hold
endmodule : uif_usb_peer
